// File: pkg/plb_consts.svh
// Constants for the programmable lookup-table logic block
`ifndef PLB_CONSTS_SVH
`define PLB_CONSTS_SVH
// ========================================
// Register byte offsets
`define PLB_OFF_BLOCK_SEL 8'h00
`define PLB_OFF_TABLE_SEL 8'h04
`define PLB_OFF_SLOT_SEL 8'h08
`define PLB_OFF_SRC_SEL 8'h0c
`define PLB_OFF_ACT_MODE 8'h10
`define PLB_OFF_ROW_IDX 8'h14
`define PLB_OFF_ROW_BIT 8'h18
`define PLB_OFF_TABLE_WORD 8'h1c
`define PLB_OFF_STATUS 8'h20
// ========================================
// Reset values, responses and legal-value counts
`define PLB_TABLE_RST 8'h00
`define PLB_RESP_OKAY 2'h0
`define PLB_RESP_SLVERR 2'h2
`define PLB_NUM_SRC 5'h13
`define PLB_NUM_SLOT 2'h3
`define PLB_NUM_ACT 3'h5
`endif

// File: pkg/plb_pkg.sv
// Types for the programmable lookup-table logic block
package plb_pkg;
  // ========================================
  // Input sources
  typedef enum logic [4:0] {
    SRC_ZERO, SRC_LINE0, SRC_LINE1, SRC_LINE2, SRC_LINE3,
    SRC_SW_OUTPUT_0, SRC_SW_OUTPUT_1, SRC_SW_OUTPUT_2, SRC_SW_OUTPUT_3,
    SRC_CNT0_BEGIN_EVT, SRC_CNT1_BEGIN_EVT, SRC_CNT0_FINISH_EVT, SRC_CNT1_FINISH_EVT,
    SRC_BLOCK0, SRC_BLOCK1, SRC_EXPO_BEGIN, SRC_EXPO_FINISH,
    SRC_FRAME_TRIG_WAITING, SRC_ACQ_RUNNING
  } plb_src_type;
  // ========================================
  // Activation modes
  typedef enum logic [2:0] {
    ACT_LEVEL_LOW, ACT_LEVEL_HIGH, ACT_FALL, ACT_RISE, ACT_BOTH_EDGES
  } plb_act_type;
  // ========================================
  // Per-input setting and camera signals
  typedef struct packed {
    plb_src_type src;
    plb_act_type act;
  } plb_input_cfg_type;
  typedef struct packed {
    logic [3:0] line;
    logic [3:0] sw_output;
    logic [1:0] cnt_begin_evt;
    logic [1:0] cnt_finish_evt;
    logic expo_begin;
    logic expo_finish;
    logic frame_trig_waiting;
    logic acq_running;
  } plb_sig_type;
  // ========================================
  // One block's configuration
  typedef struct packed {
    plb_input_cfg_type [2:0] inp;
    logic [7:0] value_table;
    logic [7:0] enable_table;
  } plb_blk_cfg_type;
endpackage : plb_pkg

// File: verilog/plb_core.sv
// One logic block: input qualifiers, two tables, output flip-flop
`timescale 1ns/1ps
`include "plb_consts.svh"
module plb_core (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Sampled sources and configuration
  input wire logic [18:0] i_src_vec,
  input wire logic [18:0] i_src_prev,
  input plb_pkg::plb_blk_cfg_type i_cfg,
  // Block output
  output logic o_out
);
  import plb_pkg::*;
  // ========================================
  // Input qualification
  logic [2:0] qual;
  logic out_r;
  logic out_nxt;
  logic [2:0] row;
  for (genvar k = 0; k < 3; k++) begin : g_in
    logic cur;
    logic prv;
    assign cur = i_src_vec[i_cfg.inp[k].src];
    assign prv = i_src_prev[i_cfg.inp[k].src];
    always_comb begin
      unique case (i_cfg.inp[k].act)
        ACT_LEVEL_LOW: qual[k] = !cur;
        ACT_LEVEL_HIGH: qual[k] = cur;
        ACT_FALL: qual[k] = prv && !cur;
        ACT_RISE: qual[k] = !prv && cur;
        ACT_BOTH_EDGES: qual[k] = prv ^ cur;
        default: qual[k] = 1'b0;
      endcase
    end
  end
  // Shared inputs feed both tables; input 2 is the row msb
  assign row = {qual[2], qual[1], qual[0]};
  // ========================================
  // Output flip-flop
  always_comb begin
    out_nxt = out_r;
    if (i_cfg.enable_table[row]) begin
      out_nxt = i_cfg.value_table[row];
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      out_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
    end
  end
  assign o_out = out_r;
  a_out_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !i_cfg.enable_table[row] |=> $stable(o_out))
    else $error("output changed while enable false");
  a_out_load: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cfg.enable_table[row] |=> o_out == $past(i_cfg.value_table[row]))
    else $error("output did not load value table");
  a_pass_thru: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cfg.enable_table == 8'hff |=> o_out == $past(i_cfg.value_table[row]))
    else $error("pass-through failed");
  // A rise qualifier must drop after one cycle unless the input setting moved
  a_edge_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_cfg.inp[0].act == ACT_RISE && qual[0]) |=> !qual[0] || $changed(i_cfg.inp[0]))
    else $error("rise qualifier lasted two cycles");
endmodule : plb_core

// File: verilog/plb_top.sv
// Two programmable logic blocks behind an AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "plb_consts.svh"
// What this block does
// - Two tables drive flip-flop data and enable
// - Each table: three inputs, eight truth bits
// - Both tables share one input selection set
// - Source setting picks each input's signal
// - Activation setting picks level or edge
// - Row index then single truth bit write
// - Whole eight-bit table in one write
// - Input2 is row msb; bit k is row k
// - Output holds unless enable table true
// - Enable all ones passes value through
// - Table selector chooses table for settings
// - Two blocks chosen by block selector
// - Sources: zero, lines, outputs, events, blocks
// - Five activation modes offered
module plb_top (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_B,
  // Camera signals
  input plb_pkg::plb_sig_type I_SIG,
  // AXI4-Lite write address and data
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  // AXI4-Lite write response
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  // AXI4-Lite read
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  // Block outputs
  output logic [1:0] O_BLOCK_OUT
);
  import plb_pkg::*;
  // ========================================
  // Configuration state
  plb_blk_cfg_type [1:0] cfg_r, cfg_nxt;
  logic blk_sel_r, blk_sel_nxt;
  logic tbl_sel_r, tbl_sel_nxt;
  logic [1:0] slot_r, slot_nxt;
  logic [2:0] row_r, row_nxt;
  // ========================================
  // Bus state
  logic aw_hold_r, aw_hold_nxt;
  logic w_hold_r, w_hold_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic do_write;
  logic wr_ok;
  // ========================================
  // Source sampling
  logic [18:0] src_vec, src_prev_r;
  logic [1:0] blk_out;
  assign src_vec = {I_SIG.acq_running, I_SIG.frame_trig_waiting, I_SIG.expo_finish,
                    I_SIG.expo_begin, blk_out, I_SIG.cnt_finish_evt, I_SIG.cnt_begin_evt,
                    I_SIG.sw_output, I_SIG.line, 1'b0};
  // Previous sample feeds edge detection
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      src_prev_r <= '0;
    end else begin
      src_prev_r <= src_vec;
    end
  end
  for (genvar b = 0; b < 2; b++) begin : g_blk
    plb_core u_core (
      .i_clk(I_CLK),
      .i_rst_b(I_RST_B),
      .i_src_vec(src_vec),
      .i_src_prev(src_prev_r),
      .i_cfg(cfg_r[b]),
      .o_out(blk_out[b])
    );
  end
  assign O_BLOCK_OUT = blk_out;
  // ========================================
  // Write channel
  assign O_AWREADY = !aw_hold_r && !bvalid_r;
  assign O_WREADY = !w_hold_r && !bvalid_r;
  always_comb begin
    logic have_aw;
    logic have_w;
    have_aw = aw_hold_r || (I_AWVALID && O_AWREADY);
    have_w = w_hold_r || (I_WVALID && O_WREADY);
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    do_write = 1'b0;
    if (I_AWVALID && O_AWREADY) begin
      awaddr_nxt = I_AWADDR;
      aw_hold_nxt = 1'b1;
    end
    if (I_WVALID && O_WREADY) begin
      wdata_nxt = I_WDATA;
      w_hold_nxt = 1'b1;
    end
    if (bvalid_r && I_BREADY) begin
      bvalid_nxt = 1'b0;
    end
    if (have_aw && have_w && !bvalid_r) begin
      do_write = 1'b1;
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_ok ? `PLB_RESP_OKAY : `PLB_RESP_SLVERR;
    end
  end
  // Address and data of the write being committed
  logic [7:0] wa;
  logic [31:0] wd;
  assign wa = (I_AWVALID && O_AWREADY) ? I_AWADDR : awaddr_r;
  assign wd = (I_WVALID && O_WREADY) ? I_WDATA : wdata_r;
  // ========================================
  // Register decode; selectors steer the indexed settings
  always_comb begin
    cfg_nxt = cfg_r;
    blk_sel_nxt = blk_sel_r;
    tbl_sel_nxt = tbl_sel_r;
    slot_nxt = slot_r;
    row_nxt = row_r;
    wr_ok = 1'b1;
    unique case (wa)
      `PLB_OFF_BLOCK_SEL: if (do_write && I_WSTRB[0]) blk_sel_nxt = wd[0];
      `PLB_OFF_TABLE_SEL: if (do_write && I_WSTRB[0]) tbl_sel_nxt = wd[0];
      `PLB_OFF_SLOT_SEL: begin
        wr_ok = wd[1:0] < `PLB_NUM_SLOT && wd[31:2] == '0;
        if (do_write && wr_ok && I_WSTRB[0]) slot_nxt = wd[1:0];
      end
      `PLB_OFF_SRC_SEL: begin
        wr_ok = wd[4:0] < `PLB_NUM_SRC && wd[31:5] == '0;
        if (do_write && wr_ok && I_WSTRB[0]) begin
          cfg_nxt[blk_sel_r].inp[slot_r].src = plb_src_type'(wd[4:0]);
        end
      end
      `PLB_OFF_ACT_MODE: begin
        wr_ok = wd[2:0] < `PLB_NUM_ACT && wd[31:3] == '0;
        if (do_write && wr_ok && I_WSTRB[0]) begin
          cfg_nxt[blk_sel_r].inp[slot_r].act = plb_act_type'(wd[2:0]);
        end
      end
      `PLB_OFF_ROW_IDX: begin
        wr_ok = wd[31:3] == '0;
        if (do_write && wr_ok && I_WSTRB[0]) row_nxt = wd[2:0];
      end
      `PLB_OFF_ROW_BIT: if (do_write && I_WSTRB[0]) begin
        if (tbl_sel_r) cfg_nxt[blk_sel_r].enable_table[row_r] = wd[0];
        else cfg_nxt[blk_sel_r].value_table[row_r] = wd[0];
      end
      `PLB_OFF_TABLE_WORD: if (do_write && I_WSTRB[0]) begin
        if (tbl_sel_r) cfg_nxt[blk_sel_r].enable_table = wd[7:0];
        else cfg_nxt[blk_sel_r].value_table = wd[7:0];
      end
      default: wr_ok = 1'b0;
    endcase
  end
  // ========================================
  // Read channel
  assign O_ARREADY = !rvalid_r;
  always_comb begin
    plb_blk_cfg_type c;
    logic [7:0] tbl;
    c = cfg_r[blk_sel_r];
    tbl = tbl_sel_r ? c.enable_table : c.value_table;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && I_RREADY) rvalid_nxt = 1'b0;
    if (I_ARVALID && O_ARREADY) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `PLB_RESP_OKAY;
      rdata_nxt = '0;
      unique case (I_ARADDR)
        `PLB_OFF_BLOCK_SEL: rdata_nxt[0] = blk_sel_r;
        `PLB_OFF_TABLE_SEL: rdata_nxt[0] = tbl_sel_r;
        `PLB_OFF_SLOT_SEL: rdata_nxt[1:0] = slot_r;
        `PLB_OFF_SRC_SEL: rdata_nxt[4:0] = c.inp[slot_r].src;
        `PLB_OFF_ACT_MODE: rdata_nxt[2:0] = c.inp[slot_r].act;
        `PLB_OFF_ROW_IDX: rdata_nxt[2:0] = row_r;
        `PLB_OFF_ROW_BIT: rdata_nxt[0] = tbl[row_r];
        `PLB_OFF_TABLE_WORD: rdata_nxt[7:0] = tbl;
        `PLB_OFF_STATUS: rdata_nxt[1:0] = blk_out;
        default: rresp_nxt = `PLB_RESP_SLVERR;
      endcase
    end
  end
  // ========================================
  // State registers
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      for (int b = 0; b < 2; b++) begin
        cfg_r[b].inp <= '0;
        cfg_r[b].value_table <= `PLB_TABLE_RST;
        cfg_r[b].enable_table <= `PLB_TABLE_RST;
      end
      blk_sel_r <= 1'b0;
      tbl_sel_r <= 1'b0;
      slot_r <= '0;
      row_r <= '0;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= `PLB_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `PLB_RESP_OKAY;
    end else begin
      cfg_r <= cfg_nxt;
      blk_sel_r <= blk_sel_nxt;
      tbl_sel_r <= tbl_sel_nxt;
      slot_r <= slot_nxt;
      row_r <= row_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end
  assign O_BVALID = bvalid_r;
  assign O_BRESP = bresp_r;
  assign O_RVALID = rvalid_r;
  assign O_RDATA = rdata_r;
  assign O_RRESP = rresp_r;
  // ========================================
  // Checks
  a_word_write: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (do_write && wa == `PLB_OFF_TABLE_WORD && I_WSTRB[0] && !tbl_sel_r)
    |=> cfg_r[$past(blk_sel_r)].value_table == $past(wd[7:0]))
    else $error("table word write lost");
  a_row_write: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (do_write && wa == `PLB_OFF_ROW_BIT && I_WSTRB[0] && tbl_sel_r)
    |=> cfg_r[$past(blk_sel_r)].enable_table[$past(row_r)] == $past(wd[0]))
    else $error("row bit write lost");
  a_row_range: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (do_write && wa == `PLB_OFF_ROW_IDX && wd > 32'h7) |=> $stable(row_r))
    else $error("row index out of range accepted");
  a_src_shared: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (do_write && wa == `PLB_OFF_TABLE_SEL) |=> $stable(cfg_r))
    else $error("table select altered input set");
  a_reset_out: assert property (@(posedge I_CLK)
    !I_RST_B |=> O_BLOCK_OUT == 2'h0)
    else $error("block output not cleared by reset");
  a_other_block: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (do_write && !blk_sel_r) |=> $stable(cfg_r[1]))
    else $error("unselected block changed");
  a_bresp_time: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    do_write |=> O_BVALID)
    else $error("write response missing");
endmodule : plb_top

// File: testbench/plb_sig_model.sv
// Behavioural model of the camera signals feeding the logic blocks
`timescale 1ns/1ps
module plb_sig_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Requested levels and driven signals
  input plb_pkg::plb_sig_type i_want,
  output plb_pkg::plb_sig_type o_sig
);
  import plb_pkg::*;
  // ======
  // Signal update
  // Levels change just after an edge, as the device's own flops would
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_sig <= '0;
    end else begin
      o_sig <= i_want;
    end
  end
endmodule : plb_sig_model

// File: testbench/plb_top_tb.sv
// Self-checking testbench for the two lookup-table logic blocks
`timescale 1ns/1ps
`include "plb_consts.svh"
module plb_top_tb;
  import plb_pkg::*;
  typedef struct packed {logic [7:0] v; logic [7:0] e; logic [2:0] in; logic q;} plb_row_type;
  // ======
  // Signals
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  plb_sig_type want = '0;
  plb_sig_type sig;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, e1, e2;
  logic [1:0] bresp, rresp, blk_out, rsp;
  logic [31:0] rdata, rd;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int c1, c2;
  // Value word, enable word, inputs 2..0, expected output
  plb_row_type rows [13] = '{20'hc0ff0, 20'hc0ff2, 20'hc0ff4, 20'hc0ff6, 20'hc0ff8,
    20'hc0ffa, 20'hc0ffd, 20'hc0fff, 20'h4060d, 20'h40601, 20'h4060a, 20'h4060e, 20'h4060d};
  logic [15:0] bad [6] = '{16'h0803, 16'h0804, 16'h0c13, 16'h1005, 16'h1408, 16'h2400};
  // Per mode: level after rise, after fall, pulses on rise, on fall
  logic [3:0] modes [5] = '{4'h4, 4'h8, 4'h1, 4'h2, 4'h3};
  always #2 clk = ~clk;
  plb_sig_model sig_model (.i_clk(clk), .i_rst_b(rst_b), .i_want(want), .o_sig(sig));
  plb_top dut (.I_CLK(clk), .I_RST_B(rst_b), .I_SIG(sig), .I_AWADDR(awaddr),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hf),
    .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .O_BLOCK_OUT(blk_out));
  // ======
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Readies are looked at on the falling edge, so no race with the rising one
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, ar_t, done;
    done = 1'b0;
    @(posedge clk);
    if (wr) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    while (!done) begin
      @(negedge clk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      ar_t = arvalid && arready;
      done = wr ? bvalid : rvalid;
      rsp = wr ? bresp : rresp;
      rd = rdata;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (ar_t) arvalid <= 1'b0;
    end
    bready <= 1'b0;
    rready <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = `PLB_RESP_OKAY);
    xfer(1'b1, a, d);
    chk({30'h0, rsp}, {30'h0, er});
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk({30'h0, rsp}, {30'h0, `PLB_RESP_OKAY});
    chk(rd, exp);
  endtask : rd_chk
  task automatic set_in(input logic [31:0] s, input logic [31:0] src, input logic [31:0] act);
    wr(`PLB_OFF_SLOT_SEL, s);
    wr(`PLB_OFF_SRC_SEL, src);
    wr(`PLB_OFF_ACT_MODE, act);
  endtask : set_in
  task automatic set_tab(input logic [31:0] t, input logic [31:0] w);
    wr(`PLB_OFF_TABLE_SEL, t);
    wr(`PLB_OFF_TABLE_WORD, w);
  endtask : set_tab
  // Source path is a model flop plus sampling, so a few cycles settle it
  task automatic put(input plb_sig_type v);
    @(posedge clk);
    want <= v;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask : put
  task automatic win(input plb_sig_type v, output int c, output logic e);
    c = 0;
    @(posedge clk);
    want <= v;
    repeat (12) begin
      @(negedge clk);
      if (blk_out[1] === 1'b1) c++;
    end
    e = blk_out[1];
  endtask : win
  function automatic logic [15:0] src_mask(input int s);
    case (s)
      1, 2, 3, 4: return 16'h1000 << (s - 1);
      5, 6, 7, 8: return 16'h0100 << (s - 5);
      9: return 16'h0040;
      10: return 16'h0080;
      11: return 16'h0010;
      12: return 16'h0020;
      15: return 16'h0008;
      16: return 16'h0004;
      17: return 16'h0002;
      18: return 16'h0001;
      default: return 16'h0000;
    endcase
  endfunction : src_mask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  // ======
  // Hang guard, well above the thousand or so cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  // ======
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({30'h0, blk_out}, 32'h0);
    @(posedge clk);
    rst_b <= 1'b1;
    wr(`PLB_OFF_BLOCK_SEL, 0);
    wr(`PLB_OFF_TABLE_SEL, 0);
    set_in(0, 1, 1);
    set_in(1, 2, 1);
    wr(`PLB_OFF_TABLE_SEL, 1);
    set_in(2, 3, 1);
    foreach (rows[i]) begin
      set_tab(1, rows[i].e);
      set_tab(0, rows[i].v);
      put({1'b0, rows[i].in, 12'h0});
      chk({30'h0, blk_out}, {31'h0, rows[i].q});
      rd_chk(`PLB_OFF_STATUS, {31'h0, rows[i].q});
    end
    set_tab(1, 8'hff);
    set_tab(0, 8'hc0);
    wr(`PLB_OFF_ROW_IDX, 0);
    wr(`PLB_OFF_ROW_BIT, 1);
    put(16'h0000);
    chk({31'h0, blk_out[0]}, 32'h1);
    wr(`PLB_OFF_ROW_IDX, 7);
    wr(`PLB_OFF_ROW_BIT, 0);
    put(16'h7000);
    chk({31'h0, blk_out[0]}, 32'h0);
    foreach (bad[i]) wr(bad[i][15:8], {24'h0, bad[i][7:0]}, `PLB_RESP_SLVERR);
    xfer(1'b0, 8'h24, 32'h0);
    chk({30'h0, rsp}, {30'h0, `PLB_RESP_SLVERR});
    rd_chk(`PLB_OFF_SLOT_SEL, 2);
    put(16'h0000);
    chk({31'h0, blk_out[0]}, 32'h1);
    wr(`PLB_OFF_BLOCK_SEL, 1);
    set_tab(1, 8'hff);
    set_tab(0, 8'haa);
    for (int s = 0; s < 19; s++) begin
      if (s == 13 || s == 14) continue;
      set_in(0, s, 1);
      put(src_mask(s));
      chk({31'h0, blk_out[1]}, {31'h0, s != 0});
      put(~src_mask(s));
      chk({31'h0, blk_out[1]}, 32'h0);
    end
    set_in(0, 13, 1);
    put(16'h0000);
    chk({30'h0, blk_out}, 32'h3);
    put(16'h7000);
    chk({30'h0, blk_out}, 32'h0);
    // Line 3 feeds block 1 only; block 0 watches lines 0 to 2
    for (int m = 0; m < 5; m++) begin
      put(16'h0000);
      set_in(0, 4, m);
      win(16'h8000, c1, e1);
      win(16'h0000, c2, e2);
      chk({30'h0, e1, e2}, {30'h0, modes[m][3:2]});
      if (m > 1) chk(c1, {31'h0, modes[m][1]});
      if (m > 1) chk(c2, {31'h0, modes[m][0]});
    end
    // Block 1 fed back on itself through a level-low input toggles every cycle
    set_in(0, 14, 0);
    win(16'h0000, c1, e1);
    chk(c1, 32'h6);
    wr(`PLB_OFF_TABLE_SEL, 1);
    wr(`PLB_OFF_ROW_IDX, 3);
    wr(`PLB_OFF_ROW_BIT, 0);
    rd_chk(`PLB_OFF_TABLE_WORD, 32'hf7);
    rd_chk(`PLB_OFF_ROW_BIT, 0);
    rd_chk(`PLB_OFF_SRC_SEL, 14);
    put(16'h0000);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({30'h0, blk_out}, 32'h0);
    chk({31'h0, awready}, 32'h1);
    @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(`PLB_OFF_STATUS, 0);
    tally_and_finish();
  end
endmodule : plb_top_tb
